// ### eds_map.svh
// Register map, field positions, reset values and timing counts of the dialer sequencer
//
// Summary of operation
// - Command mode disabled: nothing more is queued; a byte already offered still goes out.
// - Attention mode: built-in prefix, indication and escape are used with the stored phone number.
// - User mode: stored prefix, indication, escape and guard delay are used.
// - A disabled port forces the command mode to have no effect.
// - Carrier loss ends the connection; the modem must not force carrier on.
// - Dialing sends the connect prefix, then the stored phone number.
// - Connect prefix holds at most 20 ASCII characters.
// - Empty prefix: the phone number goes out with nothing ahead of it.
// - Case-sensitive match of the indication (max 20 chars) in receive data.
// - No indication within one minute of dialing abandons the attempt.
// - Empty indication: no search, a carrier-detect rise marks the connection.
// - Escape sequence (max 20 chars) goes out before a disconnect.
// - Empty escape sequence: no escape characters are sent.
// - Clearing prefix, indication or escape sets its length to zero.
// - Prefix, indication and escape are locked unless port enabled and user mode selected; the phone number needs port enabled only.
// - Only one port per carrier may take the ASCII alarm use.
// - Port stays silent for the guard delay before and after the escape.
`ifndef EDS_MAP_SVH
`define EDS_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define EDS_A_CTRL    8'h00
`define EDS_A_CMD     8'h04
`define EDS_A_STAT    8'h08
`define EDS_A_ISTAT   8'h0c
`define EDS_A_ICLR    8'h10
`define EDS_A_IEN     8'h14
`define EDS_A_STRWR   8'h18
`define EDS_A_STRLEN  8'h1c

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define EDS_CMD_DIAL   0
`define EDS_CMD_HANG   1
`define EDS_CMD_CLR    2
`define EDS_SEL_PFX    2'h0
`define EDS_SEL_IND    2'h1
`define EDS_SEL_ESC    2'h2
`define EDS_SEL_PHN    2'h3
`define EDS_IRQ_CONN   0
`define EDS_IRQ_TMO    1
`define EDS_IRQ_LOST   2
`define EDS_IRQ_DONE   3
`define EDS_CTRL_RST   7'h00
`define EDS_STR_MAX    20

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define EDS_CLK_HZ          50000000
`define EDS_TICK_US         1000
`define EDS_TICK_CYC        (`EDS_CLK_HZ / 1000000 * `EDS_TICK_US)
`define EDS_CONN_TMO_MS     60000
`define EDS_GUARD_STEP_MS   200
`define EDS_GUARD_MAX       3'h5

`endif

// ### eds_pkg.sv
// Types shared by the dialer sequencer modules
package eds_pkg;

  typedef enum logic [1:0] {
    EDS_MODE_DIS,
    EDS_MODE_AT,
    EDS_MODE_USER
  } eds_mode_t;

  typedef enum logic [2:0] {
    EDS_IDLE,
    EDS_PREFIX,
    EDS_PHONE,
    EDS_WAIT,
    EDS_ONLINE,
    EDS_GUARD1,
    EDS_ESCAPE,
    EDS_GUARD2
  } eds_state_t;

  typedef struct packed {
    logic       ascii_use;
    logic [2:0] guard;
    eds_mode_t  mode;
    logic       port_en;
  } eds_ctrl_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } eds_byte_t;

endpackage : eds_pkg

// ### eds_tick.sv
// Divider that gives a one-cycle pulse every millisecond
`timescale 1ns/100ps
module eds_tick #(
  parameter int CYC = 50000
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Tick
  output logic      tick
);

  localparam int W = $clog2(CYC);
  localparam logic [W-1:0] LAST = W'(CYC - 1);

  logic [W-1:0] cnt_ff;
  logic         tick_ff;

  assign tick = tick_ff;

  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_ff  <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= (cnt_ff == LAST) ? '0 : cnt_ff + 1'b1;
      tick_ff <= (cnt_ff == LAST);
    end
  end

endmodule : eds_tick

// ### eds_strbuf.sv
// Appendable ASCII string store with two read ports
`timescale 1ns/100ps
module eds_strbuf #(
  parameter int DEPTH = 20
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Edit
  input  wire logic       wr,
  input  wire logic [7:0] wr_char,
  input  wire logic       clr,
  // Read
  input  wire logic [4:0] rd_idx,
  output logic      [7:0] rd_char,
  output logic      [7:0] first_char,
  output logic      [4:0] len
);

  logic [7:0] mem_ff [DEPTH];
  logic [4:0] len_ff;
  wire        room = (len_ff < 5'(DEPTH));

  assign len        = len_ff;
  assign rd_char    = (rd_idx < 5'(DEPTH)) ? mem_ff[rd_idx] : 8'h00;
  assign first_char = mem_ff[0];

  always_ff @(posedge clk) begin
    if (reset || clr) begin
      len_ff <= 5'h00;
    end else if (wr && room) begin
      len_ff <= len_ff + 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (wr && room && !clr) begin
      mem_ff[len_ff] <= wr_char;
    end
  end

endmodule : eds_strbuf

// ### eds_dialer.sv
// Dial, connect-detect and escape sequencer for an external modem, with APB registers
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "eds_map.svh"
module eds_dialer import eds_pkg::*; #(
  parameter int TICK_CYC = `EDS_TICK_CYC,
  parameter int TMO_MS   = `EDS_CONN_TMO_MS
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Port transmit stream
  output logic      [7:0]  tx_data,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  // Port receive stream
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_valid,
  // Modem leads and carrier
  input  wire logic        carrier_detect,
  input  wire logic        ascii_taken,
  output logic             ascii_active,
  // Interrupt
  output logic             irq
);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  eds_ctrl_t  ctrl_ff;
  eds_state_t state_ff, nxt_state;
  logic [4:0] idx_ff, nxt_idx;
  logic [4:0] match_ff, nxt_match;
  logic [15:0] tcnt_ff, nxt_tcnt;
  eds_byte_t  tx_ff, nxt_tx;
  logic       cd_ff;
  logic [3:0] ists_ff, ien_ff;
  logic [3:0] ev;
  logic [31:0] prdata_ff;
  logic       pready_ff, irq_ff, ascii_ff;

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  wire acc     = psel && penable && pready_ff;
  wire wr      = acc && pwrite;
  wire wr_ctrl = wr && (paddr == `EDS_A_CTRL);
  wire wr_cmd  = wr && (paddr == `EDS_A_CMD);
  wire wr_iclr = wr && (paddr == `EDS_A_ICLR);
  wire wr_ien  = wr && (paddr == `EDS_A_IEN);
  wire wr_str  = wr && (paddr == `EDS_A_STRWR);

  // Effective mode: a disabled port leaves nothing active
  wire eds_mode_t mode = ctrl_ff.port_en ? ctrl_ff.mode : EDS_MODE_DIS;
  wire mode_at   = (mode == EDS_MODE_AT);
  wire mode_user = (mode == EDS_MODE_USER);
  wire str_open  = mode_user;

  wire [1:0] str_sel = pwdata[9:8];
  wire [3:0] str_wr, str_clr;

  genvar g;
  for (g = 0; g < 4; g++) begin : g_edit
    localparam logic [1:0] S = 2'(g);
    wire phone = (S == `EDS_SEL_PHN);
    assign str_wr[g]  = wr_str && (str_sel == S) && (phone ? ctrl_ff.port_en : str_open);
    assign str_clr[g] = wr_cmd && pwdata[`EDS_CMD_CLR + g]
                        && (phone ? ctrl_ff.port_en : str_open);
  end

  wire cmd_dial = wr_cmd && pwdata[`EDS_CMD_DIAL];
  wire cmd_hang = wr_cmd && pwdata[`EDS_CMD_HANG];

  // ----------------------------------------------------------------------
  // String stores
  // ----------------------------------------------------------------------
  logic [7:0] pfx_c, ind_c, esc_c, phn_c, ind_first;
  logic [4:0] pfx_len, ind_len, esc_len, phn_len;

  eds_strbuf #(.DEPTH(`EDS_STR_MAX)) u_pfx (
    .clk(clk), .reset(reset), .wr(str_wr[0]), .wr_char(pwdata[7:0]), .clr(str_clr[0]),
    .rd_idx(idx_ff), .rd_char(pfx_c), .first_char(), .len(pfx_len));
  eds_strbuf #(.DEPTH(`EDS_STR_MAX)) u_ind (
    .clk(clk), .reset(reset), .wr(str_wr[1]), .wr_char(pwdata[7:0]), .clr(str_clr[1]),
    .rd_idx(match_ff), .rd_char(ind_c), .first_char(ind_first), .len(ind_len));
  eds_strbuf #(.DEPTH(`EDS_STR_MAX)) u_esc (
    .clk(clk), .reset(reset), .wr(str_wr[2]), .wr_char(pwdata[7:0]), .clr(str_clr[2]),
    .rd_idx(idx_ff), .rd_char(esc_c), .first_char(), .len(esc_len));
  eds_strbuf #(.DEPTH(`EDS_STR_MAX)) u_phn (
    .clk(clk), .reset(reset), .wr(str_wr[3]), .wr_char(pwdata[7:0]), .clr(str_clr[3]),
    .rd_idx(idx_ff), .rd_char(phn_c), .first_char(), .len(phn_len));

  // ----------------------------------------------------------------------
  // Built-in attention strings
  // ----------------------------------------------------------------------
  function automatic logic [7:0] at_char(input logic [1:0] sel, input logic [4:0] i);
    logic [7:0] c;
    c = 8'h00;
    case (sel)
      `EDS_SEL_PFX: c = (i == 5'h0) ? 8'h41 : ((i == 5'h2) ? 8'h44 : 8'h54);
      `EDS_SEL_IND: begin
        case (i)
          5'h0:    c = 8'h43;
          5'h1:    c = 8'h4f;
          5'h2:    c = 8'h4e;
          5'h3:    c = 8'h4e;
          5'h4:    c = 8'h45;
          5'h5:    c = 8'h43;
          default: c = 8'h54;
        endcase
      end
      `EDS_SEL_ESC: c = 8'h2b;
      default:      c = 8'h00;
    endcase
    return c;
  endfunction : at_char

  function automatic logic [4:0] at_len(input logic [1:0] sel);
    return (sel == `EDS_SEL_PFX) ? 5'h4 : (sel == `EDS_SEL_IND) ? 5'h7 : 5'h3;
  endfunction : at_len

  // Character and length of the string being sent or matched
  wire [4:0] cur_pfx_len = mode_at ? at_len(`EDS_SEL_PFX) : pfx_len;
  wire [4:0] cur_esc_len = mode_at ? at_len(`EDS_SEL_ESC) : esc_len;
  wire [4:0] cur_ind_len = mode_at ? at_len(`EDS_SEL_IND) : ind_len;
  wire [7:0] cur_pfx_c   = mode_at ? at_char(`EDS_SEL_PFX, idx_ff) : pfx_c;
  wire [7:0] cur_esc_c   = mode_at ? at_char(`EDS_SEL_ESC, idx_ff) : esc_c;
  wire [7:0] cur_ind_c   = mode_at ? at_char(`EDS_SEL_IND, match_ff) : ind_c;
  wire [7:0] cur_ind_0   = mode_at ? at_char(`EDS_SEL_IND, 5'h0) : ind_first;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  logic tick;

  eds_tick #(.CYC(TICK_CYC)) u_tick (
    .clk(clk), .reset(reset), .tick(tick));

  wire [15:0] guard_ms = 16'(ctrl_ff.guard) * 16'(`EDS_GUARD_STEP_MS);
  wire [15:0] tmo_ms   = 16'(TMO_MS);
  wire        tx_idle  = !tx_ff.valid;
  wire        guard_ok = (tcnt_ff >= guard_ms);
  wire        cd_rise  = carrier_detect && !cd_ff;

  // Matcher: restart on mismatch, rechecking the same character
  wire        rx_hit   = (rx_data == cur_ind_c);
  wire        rx_first = (rx_data == cur_ind_0);
  wire [4:0]  m_step   = rx_hit ? match_ff + 5'h1 : (rx_first ? 5'h1 : 5'h0);
  wire        found    = rx_valid && (cur_ind_len != 5'h0) && (m_step == cur_ind_len);

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_idx   = idx_ff;
    nxt_match = match_ff;
    nxt_tcnt  = tcnt_ff;
    nxt_tx    = tx_ff;
    ev        = 4'h0;
    if (tx_ff.valid && tx_ready) begin
      nxt_tx.valid = 1'b0;
    end
    case (state_ff)
      EDS_IDLE: begin
        nxt_idx = 5'h0;
        if (cmd_dial && mode != EDS_MODE_DIS) begin
          nxt_state = EDS_PREFIX;
          nxt_tcnt  = 16'h0;
        end
      end
      EDS_PREFIX: begin
        if (idx_ff >= cur_pfx_len) begin
          nxt_state = EDS_PHONE;
          nxt_idx   = 5'h0;
        end else if (tx_idle) begin
          nxt_tx  = '{valid: 1'b1, data: cur_pfx_c};
          nxt_idx = idx_ff + 5'h1;
        end
      end
      EDS_PHONE: begin
        if (idx_ff >= phn_len) begin
          nxt_state = EDS_WAIT;
          nxt_match = 5'h0;
        end else if (tx_idle) begin
          nxt_tx  = '{valid: 1'b1, data: phn_c};
          nxt_idx = idx_ff + 5'h1;
        end
      end
      EDS_WAIT: begin
        if (rx_valid && cur_ind_len != 5'h0) begin
          nxt_match = m_step;
        end
        if (tick) begin
          nxt_tcnt = tcnt_ff + 16'h1;
        end
        if ((cur_ind_len == 5'h0) ? cd_rise : found) begin
          nxt_state = EDS_ONLINE;
          ev[`EDS_IRQ_CONN] = 1'b1;
        end else if (tcnt_ff >= tmo_ms || cmd_hang) begin
          nxt_state = EDS_IDLE;
          ev[`EDS_IRQ_TMO] = !cmd_hang;
        end
      end
      EDS_ONLINE: begin
        nxt_tcnt = 16'h0;
        nxt_idx  = 5'h0;
        if (!carrier_detect) begin
          nxt_state = EDS_IDLE;
          ev[`EDS_IRQ_LOST] = 1'b1;
        end else if (cmd_hang) begin
          if (cur_esc_len == 5'h0) begin
            nxt_state = EDS_IDLE;
            ev[`EDS_IRQ_DONE] = 1'b1;
          end else begin
            nxt_state = EDS_GUARD1;
          end
        end
      end
      EDS_GUARD1: begin
        if (!tx_idle) begin
          nxt_tcnt = 16'h0;
        end else if (guard_ok) begin
          nxt_state = EDS_ESCAPE;
        end else if (tick) begin
          nxt_tcnt = tcnt_ff + 16'h1;
        end
      end
      EDS_ESCAPE: begin
        if (idx_ff >= cur_esc_len) begin
          nxt_state = EDS_GUARD2;
          nxt_tcnt  = 16'h0;
        end else if (tx_idle) begin
          nxt_tx  = '{valid: 1'b1, data: cur_esc_c};
          nxt_idx = idx_ff + 5'h1;
        end
      end
      EDS_GUARD2: begin
        if (!tx_idle) begin
          nxt_tcnt = 16'h0;
        end else if (guard_ok) begin
          nxt_state = EDS_IDLE;
          ev[`EDS_IRQ_DONE] = 1'b1;
        end else if (tick) begin
          nxt_tcnt = tcnt_ff + 16'h1;
        end
      end
      default: nxt_state = EDS_IDLE;
    endcase
    // Mode dropped to disabled: stop at once, queue nothing more
    if (mode == EDS_MODE_DIS) begin
      nxt_state    = EDS_IDLE;
      nxt_tx.valid = tx_ff.valid && !tx_ready;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= EDS_IDLE;
      idx_ff   <= 5'h0;
      match_ff <= 5'h0;
      tcnt_ff  <= 16'h0;
      tx_ff    <= '0;
      cd_ff    <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      idx_ff   <= nxt_idx;
      match_ff <= nxt_match;
      tcnt_ff  <= nxt_tcnt;
      tx_ff    <= nxt_tx;
      cd_ff    <= carrier_detect;
    end
  end

  assign tx_data  = tx_ff.data;
  assign tx_valid = tx_ff.valid;

  // ----------------------------------------------------------------------
  // Control, interrupt and bus registers
  // ----------------------------------------------------------------------
  wire [2:0] wr_guard = (pwdata[5:3] > `EDS_GUARD_MAX) ? `EDS_GUARD_MAX : pwdata[5:3];
  wire       wr_ascii = pwdata[6] && !ascii_taken;

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_ff <= `EDS_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_ff <= '{ascii_use: wr_ascii, guard: wr_guard,
                   mode: (pwdata[2:1] == 2'h3) ? EDS_MODE_DIS : eds_mode_t'(pwdata[2:1]),
                   port_en: pwdata[0]};
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ists_ff <= 4'h0;
      ien_ff  <= 4'h0;
      irq_ff  <= 1'b0;
    end else begin
      ists_ff <= (ists_ff & ~(wr_iclr ? pwdata[3:0] : 4'h0)) | ev;
      ien_ff  <= wr_ien ? pwdata[3:0] : ien_ff;
      irq_ff  <= |(nxt_ists_and_en());
    end
  end

  function automatic logic [3:0] nxt_ists_and_en();
    return ((ists_ff & ~(wr_iclr ? pwdata[3:0] : 4'h0)) | ev)
           & (wr_ien ? pwdata[3:0] : ien_ff);
  endfunction : nxt_ists_and_en

  wire [31:0] rd_mux =
    (paddr == `EDS_A_CTRL)   ? 32'(ctrl_ff) :
    (paddr == `EDS_A_STAT)   ? {26'h0, carrier_detect, tx_ff.valid, 1'b0, 3'(state_ff)} :
    (paddr == `EDS_A_ISTAT)  ? {28'h0, ists_ff} :
    (paddr == `EDS_A_IEN)    ? {28'h0, ien_ff} :
    (paddr == `EDS_A_STRLEN) ? {12'h0, phn_len, esc_len, ind_len, pfx_len} :
                               32'h0;

  always_ff @(posedge clk) begin
    if (reset) begin
      pready_ff <= 1'b0;
      prdata_ff <= 32'h0;
      ascii_ff  <= 1'b0;
    end else begin
      pready_ff <= psel && penable && !pready_ff;
      prdata_ff <= (psel && penable && !pready_ff && !pwrite) ? rd_mux : prdata_ff;
      ascii_ff  <= ctrl_ff.port_en && ctrl_ff.ascii_use;
    end
  end

  assign prdata       = prdata_ff;
  assign pready       = pready_ff;
  assign pslverr      = 1'b0;
  assign irq          = irq_ff;
  assign ascii_active = ascii_ff;

endmodule : eds_dialer

// ### eds_dialer_props.sv
// Concurrent checks on the dialer sequencer ports
`timescale 1ns/100ps
module eds_dialer_props #(
  parameter int TICK_CYC = 50000,
  parameter int TMO_MS   = 60000
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Streams and leads
  input wire logic [7:0]  tx_data,
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic [7:0]  rx_data,
  input wire logic        rx_valid,
  input wire logic        carrier_detect,
  input wire logic        ascii_taken,
  input wire logic        ascii_active,
  input wire logic        irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  AST_PREADY_WAIT: assert property (psel && $rose(penable) |-> !pready ##1 pready)
    else $error("pready not after one wait state");
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_PREADY_ACC: assert property (pready |-> psel && penable && $past(penable))
    else $error("pready outside access phase");
  AST_NO_SLVERR: assert property (!pslverr)
    else $error("pslverr raised");
  AST_RST_QUIET: assert property ($fell(reset) |-> !tx_valid && !irq && !pready && !ascii_active)
    else $error("outputs active after reset");
  AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("tx byte changed before acceptance");
  AST_TX_GAP: assert property (tx_valid && tx_ready |=> !tx_valid)
    else $error("no gap after accepted byte");
  AST_ASCII_EXCL: assert property (ascii_taken [*3] |-> !$rose(ascii_active))
    else $error("ascii use taken while held elsewhere");
  AST_TX_DIS: assert property (psel && penable && pready && pwrite && paddr == 8'h00 &&
      (!pwdata[0] || pwdata[2:1] == 2'h0 || pwdata[2:1] == 2'h3)
      |-> ##3 (!$rose(tx_valid)) [*8])
    else $error("byte sent with commands disabled");
endmodule : eds_dialer_props

bind eds_dialer eds_dialer_props #(.TICK_CYC(TICK_CYC), .TMO_MS(TMO_MS)) u_props (
  .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
  .rx_valid(rx_valid), .carrier_detect(carrier_detect), .ascii_taken(ascii_taken),
  .ascii_active(ascii_active), .irq(irq));

// ### eds_modem.sv
// Behavioural modem on the far side of the port streams
`timescale 1ns/100ps
module eds_modem (
  // Clock
  input  wire logic       clk,
  // Port transmit stream, no terminal ready lead
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic       slow,
  // Port receive stream and carrier
  output logic      [7:0] rx_data,
  output logic            rx_valid,
  output logic            carrier_detect
);
  logic [7:0] got[$];
  int         got_cyc[$];
  int         cyc = 0;

  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    carrier_detect = 1'b0;
  end

  // Slow mode accepts one byte in three cycles
  assign tx_ready = !slow || (cyc % 3 == 0);

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (tx_valid && tx_ready) begin
      got.push_back(tx_data);
      got_cyc.push_back(cyc);
    end
  end

  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge clk);
      rx_data <= s[i];
      rx_valid <= 1'b1;
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_data <= ~s[i];
    end
  endtask : send

  // Carrier follows the call, never held on
  task automatic set_cd(input logic v);
    @(posedge clk);
    carrier_detect <= v;
  endtask : set_cd
endmodule : eds_modem

// ### eds_tb.sv
// Self-checking testbench of the dialer sequencer
`timescale 1ns/100ps
`include "eds_map.svh"
module tb;
  logic clk, reset, psel, penable, pwrite, pready, pslverr, tx_valid, tx_ready;
  logic rx_valid, carrier_detect, ascii_taken, ascii_active, irq, slow;
  logic [7:0]  paddr, tx_data, rx_data;
  logic [31:0] pwdata, prdata;
  int          mismatches = 0, n_checks = 0, cyc = 0, t0, t, t_first, t_last;

  eds_dialer #(.TICK_CYC(10), .TMO_MS(20)) uut (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
    .rx_valid(rx_valid), .carrier_detect(carrier_detect), .ascii_taken(ascii_taken),
    .ascii_active(ascii_active), .irq(irq));
  eds_modem modem (
    .clk(clk), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .slow(slow), .rx_data(rx_data), .rx_valid(rx_valid), .carrier_detect(carrier_detect));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      mismatches++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    q = prdata;
    chk(n, 32'h2);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rd_chk

  task automatic put(input logic [1:0] sel, input string s);
    for (int i = 0; i < s.len(); i++) wr(`EDS_A_STRWR, {22'h0, sel, s[i]});
  endtask : put

  task automatic ist(input logic [31:0] e);
    rd_chk(`EDS_A_ISTAT, e);
    wr(`EDS_A_ICLR, 32'hf);
  endtask : ist

  task automatic wait_irq(output int tt);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    chk(irq, 1'b1);
    tt = modem.cyc;
  endtask : wait_irq

  task automatic tx_chk(input string s);
    int n;
    n = 0;
    while (modem.got.size() < s.len() && n < 5000) begin
      @(posedge clk);
      n++;
    end
    repeat (20) @(posedge clk);
    chk(modem.got.size(), s.len());
    for (int i = 0; i < s.len() && i < modem.got.size(); i++) chk(modem.got[i], s[i]);
    if (modem.got.size() > 0) begin
      t_first = modem.got_cyc[0];
      t_last = modem.got_cyc[$];
    end
    modem.got.delete();
    modem.got_cyc.delete();
  endtask : tx_chk

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_regs_lock;
    rd_chk(`EDS_A_CTRL, 32'h0);
    rd_chk(8'h20, 32'h0);
    wr(8'h20, 32'hffffffff);
    rd_chk(8'h20, 32'h0);
    wr(`EDS_A_IEN, 32'hf);
    rd_chk(`EDS_A_IEN, 32'hf);
    put(`EDS_SEL_PFX, "A");
    wr(`EDS_A_CTRL, 32'h3);
    put(`EDS_SEL_PFX, "A");
    wr(`EDS_A_CTRL, 32'h4);
    put(`EDS_SEL_PFX, "A");
    rd_chk(`EDS_A_STRLEN, 32'h0);
    wr(`EDS_A_CTRL, 32'h5);
    put(`EDS_SEL_PFX, "AB");
    put(`EDS_SEL_IND, "OK");
    put(`EDS_SEL_ESC, "++");
    put(`EDS_SEL_PHN, "12");
    rd_chk(`EDS_A_STRLEN, 32'h10842);
  endtask : t_regs_lock

  task automatic t_dial_match;
    slow <= 1'b1;
    wr(`EDS_A_CMD, 32'h1);
    tx_chk("AB12");
    slow <= 1'b0;
    modem.set_cd(1'b1);
    modem.send("OOK");
    wait_irq(t);
    rd_chk(`EDS_A_STAT, 32'h24);
    wr(`EDS_A_IEN, 32'h0);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    wr(`EDS_A_IEN, 32'hf);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    ist(32'h1);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
  endtask : t_dial_match

  task automatic t_hang_guard;
    wr(`EDS_A_CTRL, 32'hd);
    t0 = modem.cyc;
    wr(`EDS_A_CMD, 32'h2);
    tx_chk("++");
    chk(t_first - t0 >= 1990 && t_first - t0 <= 2100, 1'b1);
    wait_irq(t);
    chk(t - t_last >= 1990 && t - t_last <= 2100, 1'b1);
    ist(32'h8);
    modem.set_cd(1'b0);
  endtask : t_hang_guard

  task automatic t_empty_cd;
    wr(`EDS_A_CMD, 32'h1c);
    rd_chk(`EDS_A_STRLEN, 32'h10000);
    wr(`EDS_A_CMD, 32'h1);
    tx_chk("12");
    modem.set_cd(1'b1);
    wait_irq(t);
    ist(32'h1);
    wr(`EDS_A_CMD, 32'h2);
    wait_irq(t);
    tx_chk("");
    ist(32'h8);
    modem.set_cd(1'b0);
    wr(`EDS_A_CMD, 32'h1);
    tx_chk("12");
    modem.set_cd(1'b1);
    wait_irq(t);
    ist(32'h1);
    modem.set_cd(1'b0);
    wait_irq(t);
    ist(32'h4);
  endtask : t_empty_cd

  task automatic t_timeout;
    put(`EDS_SEL_IND, "Z");
    wr(`EDS_A_CMD, 32'h1);
    tx_chk("12");
    t0 = t_last;
    wait_irq(t);
    chk(t - t0 >= 190 && t - t0 <= 260, 1'b1);
    ist(32'h2);
  endtask : t_timeout

  task automatic t_at_mode;
    wr(`EDS_A_CTRL, 32'h3);
    wr(`EDS_A_CMD, 32'h1);
    tx_chk("ATDT12");
    modem.set_cd(1'b1);
    modem.send("CONNECT");
    wait_irq(t);
    ist(32'h1);
    wr(`EDS_A_CMD, 32'h2);
    tx_chk("+++");
    wait_irq(t);
    ist(32'h8);
    modem.set_cd(1'b0);
  endtask : t_at_mode

  task automatic t_disabled;
    wr(`EDS_A_CTRL, 32'h3f);
    rd_chk(`EDS_A_CTRL, 32'h29);
    wr(`EDS_A_CTRL, 32'h1);
    wr(`EDS_A_CMD, 32'h1);
    tx_chk("");
    wr(`EDS_A_CTRL, 32'h4);
    wr(`EDS_A_CMD, 32'h1);
    tx_chk("");
    rd_chk(`EDS_A_ISTAT, 32'h0);
  endtask : t_disabled

  task automatic t_ascii;
    ascii_taken <= 1'b1;
    wr(`EDS_A_CTRL, 32'h45);
    repeat (3) @(posedge clk);
    chk(ascii_active, 1'b0);
    ascii_taken <= 1'b0;
    wr(`EDS_A_CTRL, 32'h45);
    repeat (3) @(posedge clk);
    chk(ascii_active, 1'b1);
  endtask : t_ascii

  task automatic report_and_stop;
    $display("TB: checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  initial begin
    reset = 1'b1;
    {psel, penable, pwrite, ascii_taken, slow} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_regs_lock();
    t_dial_match();
    t_hang_guard();
    t_empty_cd();
    t_timeout();
    t_at_mode();
    t_disabled();
    t_ascii();
    report_and_stop();
  end
endmodule : tb
